// ### design/exec_pkg.sv
/*
  Constants, operation codes and carrier structs for the add, AND and
  single-bit execution datapath of an 8-bit core.
  Assumes the surrounding core decodes opcodes into exec_op_e and owns the
  file register array, the program counter and the fetch pipeline.
*/
// Function
// - Add-immediate adds an 8-bit literal to the accumulator.
// - Add-file sums accumulator and file register, updating all flags.
// - For file operands, destination 0 writes the accumulator, 1 the file.
// - AND-immediate ANDs a literal into the accumulator; sets only zero.
// - AND-file ANDs a file register to the destination; sets only zero.
// - Bit-clear forces the indexed file bit to zero; flags are kept.
// - Bit-set forces the indexed file bit to one; flags are kept.
// - Test-and-skip on a zero bit turns the next instruction into a no-op.
// - Test-and-skip on a one bit skips nothing and keeps the flags.
// - Read-modify-write of a port uses the pin levels, not the latch.
`default_nettype none

package exec_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int NIBBLE_W = 4;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    op_none,
    add_immediate_to_acc,
    add_acc_and_file,
    and_immediate_with_acc,
    and_acc_with_file,
    file_bit_clear_op,
    file_bit_set_op,
    test_bit_skip_on_zero
  } exec_op_e;

  typedef struct packed {
    exec_op_e op;
    logic [DATA_W-1:0] literal;
    logic [ADDR_W-1:0] addr;
    logic [BIT_W-1:0] bit_index;
    logic dest;
  } exec_cmd_s;

  typedef struct packed {
    logic carry;
    logic low_nibble_overflow;
    logic zero;
  } exec_flags_s;

  typedef struct packed {
    logic en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_write_s;

endpackage

`default_nettype wire

// ### design/core_add_and_bit_ops_exec.sv
/*
  Execution datapath for add, AND, bit set/clear and bit-test-skip.
  Assumes the core presents one decoded command per instruction cycle
  (cmd.op = op_none when idle), returns the addressed file register value
  combinationally on file_rd_data in the same cycle, and honours skip_next
  by replacing the already fetched instruction with a no-operation.
*/
`default_nettype none

module core_add_and_bit_ops_exec
  import exec_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Decoded instruction
  input wire exec_cmd_s cmd,
  // File register read port
  input wire logic [DATA_W-1:0] file_rd_data,
  input wire logic file_is_port,
  input wire logic [DATA_W-1:0] port_pin_data,
  // Accumulator, flags, file write and fetch control
  output exec_pkg::exec_flags_s flags,
  output logic [DATA_W-1:0] acc,
  output exec_pkg::file_write_s file_wr,
  output logic skip_next
);

  // ==========================================================================
  // Operand selection and arithmetic
  // ==========================================================================
  function automatic logic [DATA_W:0] add_bytes(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    add_bytes = {1'b0, a} + {1'b0, b};
  endfunction

  function automatic logic nibble_carry(
    input logic [DATA_W-1:0] a,
    input logic [DATA_W-1:0] b
  );
    logic [NIBBLE_W:0] s;
    s = {1'b0, a[NIBBLE_W-1:0]} + {1'b0, b[NIBBLE_W-1:0]};
    nibble_carry = s[NIBBLE_W];
  endfunction

  logic [DATA_W-1:0] file_val;
  logic [DATA_W-1:0] operand;
  logic [DATA_W:0] sum;
  logic [DATA_W-1:0] result;
  logic [DATA_W-1:0] bit_mask;
  logic uses_file;
  logic is_add;
  logic is_and;

  // Ports are read from the pins so a read-modify-write does not copy a
  // stale latch value back over an input driven low externally.
  assign file_val = file_is_port ? port_pin_data : file_rd_data;
  assign uses_file = cmd.op inside {add_acc_and_file, and_acc_with_file};
  assign is_add = cmd.op inside {add_immediate_to_acc, add_acc_and_file};
  assign is_and = cmd.op inside {and_immediate_with_acc, and_acc_with_file};
  assign operand = uses_file ? file_val : cmd.literal;
  assign sum = add_bytes(acc, operand);
  assign result = is_add ? sum[DATA_W-1:0] : (acc & operand);
  assign bit_mask = DATA_W'(1) << cmd.bit_index;

  // ==========================================================================
  // Accumulator
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      acc <= ACC_RESET;
    end else if ((is_add || is_and) &&
                 (!uses_file || cmd.dest == DEST_ACC)) begin
      acc <= result;
    end
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      flags <= '0;
    end else if (is_add) begin
      flags.carry <= sum[DATA_W];
      flags.low_nibble_overflow <= nibble_carry(acc, operand);
      flags.zero <= (sum[DATA_W-1:0] == ZERO_BYTE);
    end else if (is_and) begin
      flags.zero <= (result == ZERO_BYTE);
    end
  end

  // ==========================================================================
  // File register write-back
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      file_wr <= '0;
    end else begin
      file_wr.addr <= cmd.addr;
      unique case (cmd.op)
        add_acc_and_file, and_acc_with_file: begin
          file_wr.en <= (cmd.dest == DEST_FILE);
          file_wr.data <= result;
        end
        file_bit_clear_op: begin
          file_wr.en <= 1'b1;
          file_wr.data <= file_val & ~bit_mask;
        end
        file_bit_set_op: begin
          file_wr.en <= 1'b1;
          file_wr.data <= file_val | bit_mask;
        end
        default: begin
          file_wr.en <= 1'b0;
          file_wr.data <= ZERO_BYTE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Skip request
  // ==========================================================================
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      skip_next <= 1'b0;
    end else begin
      skip_next <= (cmd.op == test_bit_skip_on_zero) &&
                   !file_val[cmd.bit_index];
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence s_add_file_to_acc;
    cmd.op == add_acc_and_file && cmd.dest == DEST_ACC;
  endsequence

  sequence s_bit_write;
    cmd.op inside {file_bit_clear_op, file_bit_set_op};
  endsequence

  sequence s_bit_test_one;
    cmd.op == test_bit_skip_on_zero && file_val[cmd.bit_index];
  endsequence

  // The flag checks work the carries out again from the operands, so a
  // broken adder or a wrong bit pick in the flag register is caught rather
  // than copied from the logic it guards.
  a_add_imm_acc: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmd.op == add_immediate_to_acc |=>
      acc == DATA_W'($past(acc) + $past(cmd.literal)))
    else $error("Add-immediate result wrong.");

  a_add_file_acc: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_add_file_to_acc |=>
      acc == DATA_W'($past(acc) + $past(file_val)) && !file_wr.en)
    else $error("Add-file to accumulator wrong.");

  a_dest_file_keep: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    uses_file && cmd.dest == DEST_FILE |=>
      $stable(acc) && file_wr.en && file_wr.addr == $past(cmd.addr))
    else $error("File destination misrouted.");

  a_and_flags_only: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    is_and |=>
      $stable(flags.carry) && $stable(flags.low_nibble_overflow))
    else $error("AND changed carry flags.");

  a_and_zero_flag: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    is_and |=>
      flags.zero == (($past(acc) & $past(operand)) == ZERO_BYTE))
    else $error("AND zero flag wrong.");

  a_bit_clear_op: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmd.op == file_bit_clear_op |=>
      file_wr.en && !file_wr.data[$past(cmd.bit_index)] && $stable(flags))
    else $error("Bit clear wrong.");

  a_bit_set_op: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmd.op == file_bit_set_op |=>
      file_wr.en && file_wr.data[$past(cmd.bit_index)] && $stable(flags))
    else $error("Bit set wrong.");

  a_bit_ops_keep: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_bit_write |=> $stable(flags) && $stable(acc))
    else $error("Bit operation touched flags or accumulator.");

  a_skip_on_zero: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmd.op == test_bit_skip_on_zero |=>
      skip_next == !$past(file_val[cmd.bit_index]) && $stable(flags))
    else $error("Skip request wrong.");

  a_skip_on_one: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    s_bit_test_one |=> !skip_next && $stable(flags) && $stable(acc))
    else $error("Skip requested on a set bit.");

  a_no_skip_else: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    cmd.op != test_bit_skip_on_zero |=> !skip_next)
    else $error("Skip without bit test.");

  a_carry_bit7: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    is_add |=>
      flags.carry == ($past(acc) > ~$past(operand)) &&
      flags.zero == (DATA_W'($past(acc) + $past(operand)) == ZERO_BYTE))
    else $error("Add flags wrong.");

  a_nibble_carry: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    is_add |=>
      flags.low_nibble_overflow ==
        ($past(acc[NIBBLE_W-1:0]) > ~$past(operand[NIBBLE_W-1:0])))
    else $error("Nibble carry wrong.");

  a_port_pins_used: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    file_is_port && cmd.op == file_bit_set_op |=>
      file_wr.data == ($past(port_pin_data) | $past(bit_mask)))
    else $error("Port latch used instead of pins.");

endmodule

`default_nettype wire

// ### test/tb_top.sv
/*
  Self-checking bench for the add, AND and single-bit execution datapath.
  Assumes the exec_pkg types and a design that answers one edge after each
  command, with file_rd_data driven here in place of the register file.
*/
`default_nettype none

module tb_top
  import exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // Signals and design under test
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  exec_cmd_s cmd = '0;
  logic [7:0] file_rd_data = 8'h00;
  logic file_is_port = 1'b0;
  logic [7:0] port_pin_data = 8'h00;
  exec_flags_s flags;
  logic [7:0] acc;
  file_write_s file_wr;
  logic skip_next;
  int miscompares = 0;
  int cmp_count = 0;
  logic [7:0] acc_m;
  logic c_m, nib_m, z_m;

  always #10 clk_sys = ~clk_sys;

  core_add_and_bit_ops_exec uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .cmd(cmd),
    .file_rd_data(file_rd_data), .file_is_port(file_is_port),
    .port_pin_data(port_pin_data), .flags(flags), .acc(acc),
    .file_wr(file_wr), .skip_next(skip_next));

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Pins off a port are fed the inverse of the latch, so a wrong pick shows.
  task automatic issue(input exec_op_e op, input logic [7:0] lit,
                       input logic [6:0] ad, input logic [2:0] bi,
                       input logic d, input logic [7:0] rd,
                       input logic prt = 1'b0, input logic [7:0] pins = 8'h00);
    logic [7:0] opnd;
    logic [7:0] res;
    logic [8:0] sum;
    logic wr;
    logic [7:0] wd;
    logic sk;
    opnd = prt ? pins : rd;
    if (op == add_immediate_to_acc || op == and_immediate_with_acc) opnd = lit;
    wr = 1'b0;
    wd = 8'h00;
    sk = 1'b0;
    res = acc_m & opnd;
    sum = {1'b0, acc_m} + {1'b0, opnd};
    if (op == add_immediate_to_acc || op == add_acc_and_file) begin
      c_m = sum[8];
      nib_m = ({1'b0, acc_m[3:0]} + {1'b0, opnd[3:0]}) > 5'h0F;
      res = sum[7:0];
    end
    if (op inside {add_immediate_to_acc, add_acc_and_file,
                   and_immediate_with_acc, and_acc_with_file}) begin
      z_m = (res == 8'h00);
      if (d && (op == add_acc_and_file || op == and_acc_with_file)) begin
        wr = 1'b1;
        wd = res;
      end else acc_m = res;
    end
    if (op == file_bit_clear_op || op == file_bit_set_op) begin
      wr = 1'b1;
      wd = (op == file_bit_set_op) ? (opnd | (8'h01 << bi))
                                   : (opnd & ~(8'h01 << bi));
    end
    if (op == test_bit_skip_on_zero) sk = ~opnd[bi];
    cmd = '{op, lit, ad, bi, d};
    file_rd_data = rd;
    file_is_port = prt;
    port_pin_data = prt ? pins : ~rd;
    @(posedge clk_sys);
    #1;
    chk({8'h00, acc}, {8'h00, acc_m}, "acc");
    chk({13'h0000, flags}, {13'h0000, c_m, nib_m, z_m}, "flags");
    chk({15'h0000, file_wr.en}, {15'h0000, wr}, "write enable");
    if (wr) chk(file_wr, {wr, ad, wd}, "write");
    chk({15'h0000, skip_next}, {15'h0000, sk}, "skip");
  endtask

  task automatic do_reset(input int n);
    cmd = '0;
    sys_rst = 1'b1;
    repeat (n) @(posedge clk_sys);
    #1 sys_rst = 1'b0;
    {acc_m, c_m, nib_m, z_m} = '0;
    chk({acc, flags, file_wr.en, skip_next}, 16'h0000, "reset state");
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_add;
    issue(add_immediate_to_acc, 8'hFC, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(add_immediate_to_acc, 8'h05, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(add_immediate_to_acc, 8'hFF, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(add_acc_and_file, 8'h00, 7'h00, 3'h0, 1'b0, 8'h0F);
    issue(add_acc_and_file, 8'h00, 7'h7F, 3'h0, 1'b1, 8'hF1);
  endtask

  task automatic t_and;
    issue(and_immediate_with_acc, 8'h05, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(and_acc_with_file, 8'h00, 7'h2A, 3'h0, 1'b1, 8'h0A);
    issue(and_acc_with_file, 8'h00, 7'h2A, 3'h0, 1'b0, 8'h84);
  endtask

  task automatic t_bits;
    for (int i = 0; i < 8; i++) begin
      issue(file_bit_clear_op, 8'h00, 7'h11, 3'(i), 1'b0, 8'hFF);
      issue(file_bit_set_op, 8'h00, 7'h12, 3'(i), 1'b0, 8'h00);
    end
    issue(file_bit_set_op, 8'h00, 7'h05, 3'h5, 1'b0, 8'hFF, 1'b1, 8'h0F);
    issue(file_bit_clear_op, 8'h00, 7'h05, 3'h0, 1'b0, 8'h00, 1'b1, 8'h0F);
    issue(add_acc_and_file, 8'h00, 7'h05, 3'h0, 1'b1, 8'h00, 1'b1, 8'h33);
  endtask

  // The instruction after a skip request is replaced here by an idle slot.
  task automatic t_skip;
    issue(test_bit_skip_on_zero, 8'h00, 7'h20, 3'h3, 1'b0, 8'hF7);
    issue(op_none, 8'h00, 7'h00, 3'h0, 1'b0, 8'h00);
    issue(test_bit_skip_on_zero, 8'h00, 7'h20, 3'h7, 1'b0, 8'h80);
    issue(add_immediate_to_acc, 8'h11, 7'h00, 3'h0, 1'b0, 8'h00);
  endtask

  task automatic t_reset;
    do_reset(1);
    issue(add_immediate_to_acc, 8'h80, 7'h00, 3'h0, 1'b0, 8'h00);
  endtask

  task automatic report_and_stop;
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    do_reset(10);
    t_add();
    t_and();
    t_bits();
    t_skip();
    t_reset();
    report_and_stop();
  end
endmodule

`default_nettype wire
